// ==== design/tcp_timer_pair.sv ====
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Two timer/counter units with an AXI4-Lite register slave
// Behaviour
// - Count pin sampled per cycle, falling edge counted
// - Source select one counts pin falling edges
// - Run bit enables counting when not gated
// - Gating plus run lets irq pin control
// - Unit A rollover sets its overflow flag
// - Unit B rollover sets its overflow flag unless unit A is in mode 3
// - Unit A uses low mode nibble
// - Unit B uses high mode nibble
// - Mode 0: five-bit prescaler feeds high register
// - Mode 1: sixteen-bit cascaded counter
// - Mode 2: low reloads from high on overflow
// - Mode 2: high register write never disturbs current count
// - Acknowledge from core clears overflow flag
// - Unit A mode 3: low is own timer
// - Unit A mode 3: high uses B run bit and B flag, not B gate
// - Unit B mode 3 halts and holds count
// - Unit B overflow drives baud rate tick
// - Timer counts once per six-clock peripheral cycle
// - Gated: count only while irq pin high
// - Mode bits decode to modes zero to three
// - One overflow interrupt source per unit
module tcp_timer_pair import tcp_pkg::*; #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // External pins
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  // Core interrupt handshake and baud clock
  input wire logic irq_ack_a,
  input wire logic irq_ack_b,
  output logic unit_a_irq,
  output logic unit_b_irq,
  output logic baud_tick
);
  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W must be at least 8");
  end

  logic [3:0] pin_in;
  logic [3:0] sync1_q, sync2_q;
  logic [1:0] samp_q;
  logic [1:0] fall;
  logic [PER_CNT_W-1:0] per_cnt_q;
  logic tick;
  logic [7:0] timer_mode_register_q;
  logic unit_a_run_bit_q, unit_b_run_bit_q;
  logic unit_a_overflow_flag_q, unit_b_overflow_flag_q;
  tcp_mode_t mode_a, mode_b;
  logic a_split;
  logic en_a, en_b;
  logic set_a, set_b;
  logic [7:0] unit_a_count_low, unit_a_count_high;
  logic [7:0] unit_b_count_low, unit_b_count_high;
  logic ovf_lo_a, ovf_hi_a, ovf_lo_b;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic do_wr;
  logic [ADDR_W-1:0] wa, ra;
  logic wr_mode, wr_ctrl, wr_hit;
  logic [3:0] wr_cnt;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [7:0] timer_control_register;

  // Two-stage synchronisers on all pins
  assign pin_in = {ext_irq_b_pin, ext_irq_a_pin, count_pin_b, count_pin_a};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else if (ce) begin
        sync1_q[i] <= pin_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // Peripheral cycle strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q <= '0;
    end else if (ce) begin
      per_cnt_q <= tick ? '0 : per_cnt_q + PER_CNT_W'(1);
    end
  end
  assign tick = per_cnt_q == PER_CNT_W'(PER_CLKS - 1);

  // Count pins sampled once per peripheral cycle; edge counted on the same tick that first samples the pin low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_q <= 2'h0;
    end else if (ce && tick) begin
      samp_q <= sync2_q[1:0];
    end
  end
  assign fall = {2{tick}} & samp_q & ~sync2_q[1:0];

  // Configuration decode
  assign mode_a = tcp_mode_t'(timer_mode_register_q[MOD_A_LSB+FLD_MODE_LSB +: 2]);
  assign mode_b = tcp_mode_t'(timer_mode_register_q[MOD_B_LSB+FLD_MODE_LSB +: 2]);
  assign a_split = mode_a == MODE_SPLIT;
  assign en_a = unit_a_run_bit_q && (!timer_mode_register_q[MOD_A_LSB+FLD_GATE] || sync2_q[2]);
  // B loses its run bit to A in split mode; it is switched by its own mode then
  assign en_b = (a_split || unit_b_run_bit_q) &&
    (!timer_mode_register_q[MOD_B_LSB+FLD_GATE] || sync2_q[3]);

  tcp_unit #(.SPLIT_OK(1'b1)) u_a (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .tick(tick), .fall_evt(fall[0]),
    .src_sel(timer_mode_register_q[MOD_A_LSB+FLD_SRC]),
    .mode(mode_a), .run_en(en_a), .hi_run(unit_b_run_bit_q),
    .wr_lo(wr_cnt[0]), .wr_hi(wr_cnt[1]), .wdata(wbyte_q),
    .lo_q(unit_a_count_low), .hi_q(unit_a_count_high),
    .ovf_lo(ovf_lo_a), .ovf_hi(ovf_hi_a)
  );

  tcp_unit #(.SPLIT_OK(1'b0)) u_b (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .tick(tick), .fall_evt(fall[1]),
    .src_sel(timer_mode_register_q[MOD_B_LSB+FLD_SRC]),
    .mode(mode_b), .run_en(en_b), .hi_run(1'b0),
    .wr_lo(wr_cnt[2]), .wr_hi(wr_cnt[3]), .wdata(wbyte_q),
    .lo_q(unit_b_count_low), .hi_q(unit_b_count_high),
    .ovf_lo(ovf_lo_b), .ovf_hi()
  );

  // Overflow flags: hardware set beats acknowledge and software write
  assign set_a = ovf_lo_a;
  assign set_b = a_split ? ovf_hi_a : ovf_lo_b;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_a_overflow_flag_q <= CTL_BIT_RST;
    end else if (ce) begin
      if (set_a) begin
        unit_a_overflow_flag_q <= 1'b1;
      end else if (irq_ack_a) begin
        unit_a_overflow_flag_q <= 1'b0;
      end else if (wr_ctrl) begin
        unit_a_overflow_flag_q <= wbyte_q[CTL_FLAG_A];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_b_overflow_flag_q <= CTL_BIT_RST;
    end else if (ce) begin
      if (set_b) begin
        unit_b_overflow_flag_q <= 1'b1;
      end else if (irq_ack_b) begin
        unit_b_overflow_flag_q <= 1'b0;
      end else if (wr_ctrl) begin
        unit_b_overflow_flag_q <= wbyte_q[CTL_FLAG_B];
      end
    end
  end
  assign unit_a_irq = unit_a_overflow_flag_q;
  assign unit_b_irq = unit_b_overflow_flag_q;

  // Baud clock keeps running even when A has taken the B flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_tick <= 1'b0;
    end else if (ce) begin
      baud_tick <= ovf_lo_b;
    end
  end

  // Mode and run bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_mode_register_q <= MODE_RST;
      unit_a_run_bit_q <= CTL_BIT_RST;
      unit_b_run_bit_q <= CTL_BIT_RST;
    end else if (ce) begin
      if (wr_mode) begin
        timer_mode_register_q <= wbyte_q;
      end
      if (wr_ctrl) begin
        unit_a_run_bit_q <= wbyte_q[CTL_RUN_A];
        unit_b_run_bit_q <= wbyte_q[CTL_RUN_B];
      end
    end
  end

  // Write channel: address and data taken in either order
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Write decode; only byte lane 0 carries register data
  assign wa = {awaddr_q[ADDR_W-1:2], 2'h0};
  assign wr_mode = do_wr && wlane_q && wa == ADDR_W'(OFS_MODE);
  assign wr_ctrl = do_wr && wlane_q && wa == ADDR_W'(OFS_CTRL);
  assign wr_cnt[0] = do_wr && wlane_q && wa == ADDR_W'(OFS_A_LOW);
  assign wr_cnt[1] = do_wr && wlane_q && wa == ADDR_W'(OFS_A_HIGH);
  assign wr_cnt[2] = do_wr && wlane_q && wa == ADDR_W'(OFS_B_LOW);
  assign wr_cnt[3] = do_wr && wlane_q && wa == ADDR_W'(OFS_B_HIGH);
  assign wr_hit = wa == ADDR_W'(OFS_MODE) || wa == ADDR_W'(OFS_CTRL) || wa == ADDR_W'(OFS_A_LOW) ||
    wa == ADDR_W'(OFS_A_HIGH) || wa == ADDR_W'(OFS_B_LOW) || wa == ADDR_W'(OFS_B_HIGH);

  // Read path
  assign timer_control_register = {unit_b_overflow_flag_q, unit_b_run_bit_q,
    unit_a_overflow_flag_q, unit_a_run_bit_q, 4'h0};
  assign ra = {araddr[ADDR_W-1:2], 2'h0};
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (ra == ADDR_W'(OFS_MODE)) begin
      rd_byte = timer_mode_register_q;
    end else if (ra == ADDR_W'(OFS_CTRL)) begin
      rd_byte = timer_control_register;
    end else if (ra == ADDR_W'(OFS_A_LOW)) begin
      rd_byte = unit_a_count_low;
    end else if (ra == ADDR_W'(OFS_A_HIGH)) begin
      rd_byte = unit_a_count_high;
    end else if (ra == ADDR_W'(OFS_B_LOW)) begin
      rd_byte = unit_b_count_low;
    end else if (ra == ADDR_W'(OFS_B_HIGH)) begin
      rd_byte = unit_b_count_high;
    end else begin
      rd_hit = 1'b0;
    end
  end
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_flag_a_set: assert property (ce && ovf_lo_a |=> unit_a_irq)
    else $error("unit A overflow did not set flag");
  a_flag_b_set: assert property (ce && set_b |=> unit_b_irq)
    else $error("unit B overflow did not set flag");
  a_ack_clears: assert property (ce && irq_ack_a && !set_a |=> !unit_a_irq)
    else $error("acknowledge did not clear flag");
  a_timer_rate: assert property (ce && tick && en_a && mode_a == MODE_16B &&
    !timer_mode_register_q[MOD_A_LSB+FLD_SRC] && !wr_cnt[0] && !wr_cnt[1] |=>
    {unit_a_count_high, unit_a_count_low} == $past({unit_a_count_high, unit_a_count_low}) + 16'h0001)
    else $error("timer did not step on peripheral cycle");
  a_counter_src: assert property (timer_mode_register_q[MOD_A_LSB+FLD_SRC] && !fall[0] &&
    mode_a == MODE_16B && !wr_cnt[0] && !wr_cnt[1] |=> $stable(unit_a_count_low))
    else $error("counter moved without pin edge");
  a_gate_block: assert property (timer_mode_register_q[MOD_A_LSB+FLD_GATE] && !sync2_q[2] &&
    mode_a != MODE_SPLIT && !wr_cnt[0] && !wr_cnt[1] |=> $stable(unit_a_count_low))
    else $error("gated unit counted with pin low");
  a_run_off: assert property (!unit_a_run_bit_q && mode_a != MODE_SPLIT && !wr_cnt[0] && !wr_cnt[1]
    |=> $stable(unit_a_count_low) && $stable(unit_a_count_high)) else $error("stopped unit counted");
  a_baud_pulse: assert property (ce && ovf_lo_b |=> baud_tick ##1 !baud_tick[*1] or !ce)
    else $error("baud tick missing");
  a_write_resp: assert property (do_wr && ce |=> bvalid) else $error("write not answered");
  c_split_hi: cover property (a_split && ovf_hi_a);
  c_pin_edge: cover property (fall[0] && en_a);
  c_gated_run: cover property (en_b && timer_mode_register_q[MOD_B_LSB+FLD_GATE]);
endmodule

// ==== design/tcp_pkg.sv ====
// Shared constants and types for the timer/counter pair
package tcp_pkg;
  // Clock periods per peripheral cycle
  localparam int unsigned PER_CLKS = 6;
  localparam int unsigned PER_CNT_W = 3;
  // Prescaler width in mode 0
  localparam int unsigned PRESC_W = 5;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_A_LOW = 8'h08;
  localparam logic [7:0] OFS_A_HIGH = 8'h0C;
  localparam logic [7:0] OFS_B_LOW = 8'h10;
  localparam logic [7:0] OFS_B_HIGH = 8'h14;
  // Mode register: nibble base per unit, field positions inside a nibble
  localparam int unsigned MOD_A_LSB = 0;
  localparam int unsigned MOD_B_LSB = 4;
  localparam int unsigned FLD_MODE_LSB = 0;
  localparam int unsigned FLD_SRC = 2;
  localparam int unsigned FLD_GATE = 3;
  // Control register bits
  localparam int unsigned CTL_RUN_A = 4;
  localparam int unsigned CTL_FLAG_A = 5;
  localparam int unsigned CTL_RUN_B = 6;
  localparam int unsigned CTL_FLAG_B = 7;
  // Values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic CTL_BIT_RST = 1'b0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MODE_13B, MODE_16B, MODE_RELOAD, MODE_SPLIT} tcp_mode_t;
endpackage

// ==== design/tcp_unit.sv ====
`timescale 1ns/100ps
// One timer/counter unit: count registers and mode logic
module tcp_unit import tcp_pkg::*; #(
  parameter bit SPLIT_OK = 1'b1
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Count sources and control
  input wire logic tick,
  input wire logic fall_evt,
  input wire logic src_sel,
  input wire tcp_mode_t mode,
  input wire logic run_en,
  input wire logic hi_run,
  // Software writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  // Counts and overflow pulses
  output logic [7:0] lo_q,
  output logic [7:0] hi_q,
  output logic ovf_lo,
  output logic ovf_hi
);
  logic [7:0] lo_d;
  logic [7:0] hi_d;
  logic inc;
  logic hi_inc;

  assign inc = run_en && (src_sel ? fall_evt : tick);
  assign hi_inc = SPLIT_OK && tick && hi_run;

  always_comb begin
    lo_d = lo_q;
    hi_d = hi_q;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;
    unique case (mode)
      MODE_13B: begin
        // Upper low bits are left alone; software must ignore them
        if (inc) begin
          lo_d[PRESC_W-1:0] = lo_q[PRESC_W-1:0] + PRESC_W'(1);
          if (&lo_q[PRESC_W-1:0]) begin
            hi_d = hi_q + 8'h01;
            ovf_lo = &hi_q;
          end
        end
      end
      MODE_16B: begin
        if (inc) begin
          {hi_d, lo_d} = {hi_q, lo_q} + 16'h0001;
          ovf_lo = &{hi_q, lo_q};
        end
      end
      MODE_RELOAD: begin
        if (inc) begin
          if (&lo_q) begin
            lo_d = hi_q;
            ovf_lo = 1'b1;
          end else begin
            lo_d = lo_q + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        // Second unit simply holds here
        if (SPLIT_OK) begin
          if (inc) begin
            lo_d = lo_q + 8'h01;
            ovf_lo = &lo_q;
          end
          if (hi_inc) begin
            hi_d = hi_q + 8'h01;
            ovf_hi = &hi_q;
          end
        end
      end
    endcase
    // Software write wins; reload value takes effect on next reload only
    if (wr_lo) begin
      lo_d = wdata;
    end
    if (wr_hi) begin
      hi_d = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_q <= CNT_RST;
      hi_q <= CNT_RST;
    end else if (ce) begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reload_value: assert property (ce && mode == MODE_RELOAD && inc && (&lo_q) && !wr_lo |=>
    lo_q == $past(hi_q)) else $error("reload did not load high register");
  a_split_hold: assert property (!SPLIT_OK && mode == MODE_SPLIT && !wr_lo && !wr_hi |=>
    $stable(lo_q) && $stable(hi_q)) else $error("halted unit changed count");
  c_reload_ovf: cover property (ce && mode == MODE_RELOAD && ovf_lo);
endmodule

// ==== test/tcp_far_side.sv ====
`timescale 1ns/100ps
// Far side model: core acknowledge plus count and gate pin drivers
module tcp_far_side #(
  parameter int unsigned HOLD = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic gate_lvl,
  input wire logic ack_en,
  // Device side
  input wire logic [1:0] irq,
  output logic [1:0] ack,
  output logic count_pin,
  output logic gate_pin,
  output logic busy
);
  logic [7:0] rem_q;
  logic [5:0] ph_q;
  assign busy = (rem_q != 8'h00);
  assign gate_pin = gate_lvl;
  // Each level held two peripheral cycles, margin over the minimum
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rem_q <= 8'h00;
      ph_q <= 6'h00;
      count_pin <= 1'b1;
    end else if (go) begin
      rem_q <= n_pulses;
      ph_q <= 6'h00;
    end else if (busy) begin
      ph_q <= (ph_q == 6'(2 * HOLD - 1)) ? 6'h00 : ph_q + 6'h01;
      if (ph_q == 6'(HOLD - 1)) begin
        count_pin <= 1'b0;
      end
      if (ph_q == 6'(2 * HOLD - 1)) begin
        count_pin <= 1'b1;
        rem_q <= rem_q - 8'h01;
      end
    end
  end
  // Core vectors once per raised flag; the pulse itself clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack <= 2'h0;
    end else begin
      ack <= {2{ack_en}} & irq & ~ack;
    end
  end
endmodule

// ==== test/tcp_timer_pair_tb.sv ====
`timescale 1ns/100ps
// Self-checking bench for the timer/counter pair
module tcp_timer_pair_tb import tcp_pkg::*;;
  logic aclk, aresetn, ce;
  logic [7:0] awaddr, araddr, n_pulses;
  logic awvalid, wvalid, bready, arvalid, rready, go, gate_lvl, ack_en;
  logic awready, wready, bvalid, arready, rvalid, busy, count_pin, gate_pin;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ack, last_bresp;
  logic unit_a_irq, unit_b_irq, baud_tick;
  int bad_count, checked, baud_cnt, b0;

  tcp_timer_pair dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .count_pin_a(count_pin),
    .count_pin_b(count_pin), .ext_irq_a_pin(gate_pin), .ext_irq_b_pin(gate_pin), .irq_ack_a(ack[0]),
    .irq_ack_b(ack[1]), .unit_a_irq(unit_a_irq), .unit_b_irq(unit_b_irq), .baud_tick(baud_tick));

  tcp_far_side far (.aclk(aclk), .aresetn(aresetn), .go(go), .n_pulses(n_pulses), .gate_lvl(gate_lvl),
    .ack_en(ack_en), .irq({unit_b_irq, unit_a_irq}), .ack(ack), .count_pin(count_pin),
    .gate_pin(gate_pin), .busy(busy));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (baud_tick === 1'b1) begin
      baud_cnt++;
    end
  end

  task finish_test;
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task timed_out(input int n);
    if (n >= 100) begin
      bad_count++;
      $display("Error bus wait expected answer seen none");
      finish_test;
    end
  endtask

  task axi_write(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    last_bresp = bresp;
    timed_out(n);
  endtask

  task axi_read(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    timed_out(n);
    check("rdata", {24'h00_0000, e}, rdata);
    check("rresp", er, rresp);
  endtask

  // Configure while stopped, run a window of k clocks, stop, read back
  task scen(input logic [7:0] md, base, lo, hi, ctl, elo, ehi, input logic [1:0] eirq, input int k,
            input logic [7:0] np);
    axi_write(OFS_MODE, md);
    axi_write(base, lo);
    axi_write(base + 8'h04, hi);
    axi_write(OFS_CTRL, ctl);
    n_pulses <= np;
    go <= 1'b1;
    repeat (k - 3) begin
      @(posedge aclk);
      go <= 1'b0;
    end
    check("irq_flags", eirq, {unit_b_irq, unit_a_irq});
    axi_write(OFS_CTRL, 8'h00);
    axi_read(base, elo, RESP_OKAY);
    axi_read(base + 8'h04, ehi, RESP_OKAY);
  endtask

  initial begin
    int n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go, gate_lvl, ack_en} = '0;
    {awaddr, araddr, n_pulses, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    bad_count = 0;
    checked = 0;
    baud_cnt = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      axi_read(8'(i * 4), 8'h00, RESP_OKAY);
    end
    axi_read(8'h18, 8'h00, RESP_SLVERR);
    axi_write(8'h18, 8'hFF);
    check("bresp", RESP_SLVERR, last_bresp);
    axi_write(OFS_CTRL, 8'h0F);
    axi_read(OFS_CTRL, 8'h00, RESP_OKAY);
    axi_write(OFS_MODE, 8'hA5);
    axi_read(OFS_MODE, 8'hA5, RESP_OKAY);
    scen(8'h01, OFS_A_LOW, 8'hFE, 8'hFF, 8'h10, 8'h08, 8'h00, 2'b01, 60, 8'h00);
    scen(8'h00, OFS_A_LOW, 8'hFE, 8'hFF, 8'h10, 8'hE8, 8'h00, 2'b01, 60, 8'h00);
    b0 = baud_cnt;
    scen(8'h20, OFS_B_LOW, 8'hFE, 8'hF0, 8'h40, 8'hF8, 8'hF0, 2'b10, 60, 8'h00);
    check("baud_ticks", 1, baud_cnt - b0);
    axi_write(OFS_B_HIGH, 8'h33);
    axi_read(OFS_B_LOW, 8'hF8, RESP_OKAY);
    // Gate pin set well ahead so the synchroniser has settled
    for (int g = 0; g < 2; g++) begin
      gate_lvl <= g[0];
      scen(8'h09, OFS_A_LOW, 8'h00, 8'h00, 8'h10, 8'(g * 10), 8'h00, 2'b00, 60, 8'h00);
    end
    scen(8'h05, OFS_A_LOW, 8'h00, 8'h00, 8'h10, 8'h05, 8'h00, 2'b00, 200, 8'h05);
    // Unit B as gated pin counter, gate pin still high from the loop above
    scen(8'hD0, OFS_B_LOW, 8'h00, 8'h00, 8'h40, 8'h05, 8'h00, 2'b00, 200, 8'h05);
    check("pulses_done", 1'b0, busy);
    scen(8'h03, OFS_A_LOW, 8'hFE, 8'h00, 8'h10, 8'h08, 8'h00, 2'b01, 60, 8'h00);
    scen(8'h03, OFS_A_LOW, 8'h00, 8'hFE, 8'h40, 8'h00, 8'h08, 2'b10, 60, 8'h00);
    scen(8'h30, OFS_B_LOW, 8'h44, 8'h55, 8'h40, 8'h44, 8'h55, 2'b00, 60, 8'h00);
    wstrb <= 4'hE;
    axi_write(OFS_A_LOW, 8'h77);
    wstrb <= 4'hF;
    axi_read(OFS_A_LOW, 8'h00, RESP_OKAY);
    axi_write(OFS_CTRL, 8'hA0);
    check("irq_flags_set", 2'b11, {unit_b_irq, unit_a_irq});
    ack_en <= 1'b1;
    n = 0;
    while ({unit_b_irq, unit_a_irq} !== 2'b00 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    check("irq_a_acked", 1'b0, unit_a_irq);
    check("irq_b_acked", 1'b0, unit_b_irq);
    axi_read(OFS_CTRL, 8'h00, RESP_OKAY);
    finish_test;
  end
endmodule
